// ### common/health_defs.svh
// Purpose: offsets, field positions, reset values and timing counts of the health monitor
// Assumes: 250 MHz core clock
// Notes: byte addresses on the plain register port
`ifndef HEALTH_DEFS_SVH
`define HEALTH_DEFS_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define A_CTRL 8'h00
`define A_STATUS 8'h04
`define A_SENSE 8'h08
`define A_REMAIN 8'h0C
`define A_TEMP_CUR 8'h10
`define A_TEMP_REF 8'h14
`define A_CMD 8'h18
`define A_LOG_SEL 8'h1C
`define A_LOG_DATA 8'h20
// ----------------------------------------
// Field positions
// ----------------------------------------
`define C_DIS 0
`define C_ONL 1
`define C_TWE 2
`define C_RPT_HI 7
`define C_RPT_LO 4
`define CMD_REZERO 0
`define CMD_FC_HI 7
`define CMD_FC_LO 5
`define S_PFA 0
`define S_TWARN 1
`define S_ROUND 2
`define S_BUSY 3
// ----------------------------------------
// Values
// ----------------------------------------
`define REF_RST 8'h41
`define REF_MAX 8'h41
`define DRIVE_MAX_C 8'h46
`define FC_SHORT 3'h1
`define FC_EXT 3'h2
`define RES_PASS 4'h0
`define RES_ELEC 4'h3
`define RES_SCAN 4'h7
`define RES_RUN 4'hF
`define LOG_DEPTH 20
`define NATTR 4
`define PFA_KEY 8'h01
`define PFA_ASC 8'h5D
`define PFA_ASCQ 8'h00
`define TW_KEY 8'h01
`define TW_ASC 8'h0B
`define TW_ASCQ 8'h01
`define RND_KEY 8'h01
`define RND_ASC 8'h37
`define RND_ASCQ 8'h00
`define SHORT_SCAN_BLOCKS 32'h0001_0000
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 250
`define SEC_CYCLES (`CLK_MHZ * 1000000)
`define MEAS_PERIOD_S 3600
`define TEMP_PERIOD_S 600
`define SHORT_TEST_S 120
`define MAX_DELAY_MS 75
`define DELAY_CYCLES (`MAX_DELAY_MS * `CLK_MHZ * 1000)
`define MEAS_CYCLES 1000000
`define IDLE_NS 1000
`define IDLE_CYCLES (`IDLE_NS * `CLK_MHZ / 1000)
`endif

// ### common/health_pkg.sv
// Purpose: shared types of the health monitor
// Assumes: nothing
// Notes: none
`default_nettype none
package health_pkg;
  typedef struct packed {
    logic [7:0] key;
    logic [7:0] asc;
    logic [7:0] ascq;
    logic [7:0] unit_code;
  } sense_s;
  typedef struct packed {
    logic [15:0] interval;
    logic [15:0] err_thr;
    logic [7:0] pred_thr;
  } attr_cfg_s;
  typedef struct packed {
    logic req;
    logic scan;
    logic [31:0] lba;
  } step_s;
  typedef enum logic [1:0] {ST_IDLE, ST_ELEC, ST_SCAN} test_ph_e;
  typedef enum logic {M_WAIT, M_MEAS} meas_e;
endpackage
`default_nettype wire

// ### design/attr_rate_tracker.sv
// Purpose: error-rate tracking of one monitored attribute
// Assumes: op and err are one-cycle pulses
// Notes: history saturates at 255
`timescale 1ns/1ps
`default_nettype none
`include "health_defs.svh"
module attr_rate_tracker (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Sync reset
  input wire logic en, // Monitoring active
  input wire logic op, // One operation done
  input wire logic err, // One error seen
  input wire health_pkg::attr_cfg_s cfg, // Limits
  output logic pfa // Predictive failure
);
  import health_pkg::*;
  typedef struct packed {
    logic [15:0] ivl;
    logic [15:0] fails;
    logic [7:0] hist;
    logic pfa;
  } trk_s;
  trk_s q, d;
  logic bad, good;
  always_comb begin
    d = q;
    bad = 1'b0;
    good = 1'b0;
    if (en) begin
      if (err) d.fails = q.fails + 16'h0001;
      if (op) d.ivl = q.ivl + 16'h0001;
      // The error that takes the count past the threshold closes the interval
      if (err && q.fails >= cfg.err_thr) bad = 1'b1; // RULE9
      else if (op && d.ivl >= cfg.interval) good = 1'b1; // RULE9
      if (bad || good) begin
        d.ivl = '0; // RULE9
        d.fails = '0;
      end
      if (bad && q.hist != 8'hFF) d.hist = q.hist + 8'h01; // RULE10
      else if (good && q.hist != 8'h00) d.hist = q.hist - 8'h01; // RULE10
    end
    d.pfa = (cfg.pred_thr != 8'h00) && (d.hist >= cfg.pred_thr); // RULE11
  end
  always_ff @(posedge core_clk) begin
    if (rst) q <= '0;
    else q <= d;
  end
  assign pfa = q.pfa;
  property p_hist_up;
    @(posedge core_clk) disable iff (rst) (bad && q.hist != 8'hFF) |=> q.hist == $past(q.hist) + 8'h01;
  endproperty
  a_hist_up: assert property (p_hist_up) else $error("history did not count up"); // RULE10
  property p_hist_floor;
    @(posedge core_clk) disable iff (rst) (good && q.hist == 8'h00) |=> q.hist == 8'h00 && q.ivl == 16'h0;
  endproperty
  a_hist_floor: assert property (p_hist_floor) else $error("history went below zero"); // RULE10
endmodule // attr_rate_tracker
`default_nettype wire

// ### design/self_test_engine.sv
// Purpose: short and extended drive self-test sequencer
// Assumes: step_ack is a one-cycle pulse while step.req is high
// Notes: only unrecovered errors are reported by the step partner
`timescale 1ns/1ps
`default_nettype none
`include "health_defs.svh"
module self_test_engine (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Sync reset
  input wire logic sec_tick, // One-second enable
  input wire logic start, // Start pulse
  input wire logic [2:0] fcode, // Function code
  input wire logic [31:0] max_lba, // Last block address
  input wire logic step_ack, // Step finished
  input wire logic step_unrec, // Step failed after all retries
  output health_pkg::step_s step, // Step request
  output logic busy, // Test running
  output logic done, // Test finished pulse
  output logic [3:0] result // Last result
);
  import health_pkg::*;
  typedef struct packed {
    test_ph_e ph;
    logic ext;
    logic [6:0] secs;
    step_s step;
    logic done;
    logic [3:0] result;
  } st_s;
  st_s q, d;
  logic [31:0] last;
  always_comb begin
    d = q;
    d.done = 1'b0;
    // Short test scans only the first SHORT_SCAN_BLOCKS blocks, or the whole of smaller media
    last = (q.ext || max_lba < `SHORT_SCAN_BLOCKS) ? max_lba : `SHORT_SCAN_BLOCKS - 32'h1; // RULE21
    unique case (q.ph)
      ST_IDLE: begin
        if (start && (fcode == `FC_SHORT || fcode == `FC_EXT)) begin // RULE18
          d.ph = ST_ELEC; // RULE21
          d.ext = (fcode == `FC_EXT);
          d.secs = '0;
          d.step = '{req: 1'b1, scan: 1'b0, lba: 32'h0};
        end
      end
      ST_ELEC: begin
        if (step_ack && step_unrec) begin // RULE22
          d.ph = ST_IDLE;
          d.step.req = 1'b0;
          d.done = 1'b1;
          d.result = `RES_ELEC;
        end else if (step_ack) begin
          d.ph = ST_SCAN; // RULE21
          d.step.scan = 1'b1;
        end
      end
      ST_SCAN: begin
        if (sec_tick) d.secs = q.secs + 7'h01;
        if (!q.ext && q.secs >= 7'(`SHORT_TEST_S)) begin // RULE20
          d.ph = ST_IDLE;
          d.step.req = 1'b0;
          d.done = 1'b1;
          d.result = `RES_PASS;
        end else if (step_ack) begin
          if (step_unrec || q.step.lba == last) begin // RULE22
            d.ph = ST_IDLE;
            d.step.req = 1'b0;
            d.done = 1'b1;
            d.result = step_unrec ? `RES_SCAN : `RES_PASS; // RULE24
          end else begin
            d.step.lba = q.step.lba + 32'h1; // RULE21
          end
        end
      end
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (rst) q <= '0;
    else q <= d;
  end
  assign step = q.step;
  assign busy = (q.ph != ST_IDLE);
  assign done = q.done;
  assign result = q.result;
  property p_short_limit;
    @(posedge core_clk) disable iff (rst) (q.ph != ST_IDLE && !q.ext) |-> q.secs <= 7'(`SHORT_TEST_S);
  endproperty
  a_short_limit: assert property (p_short_limit) else $error("short test overran"); // RULE20
endmodule // self_test_engine
`default_nettype wire

// ### design/drive_health_monitor.sv
// Purpose: drive health monitor: rate tracking, thermal warnings, measurement timer, self-test
// Assumes: inputs synchronous to core_clk, single-cycle register strobes
// Notes: nv_* inputs are read once, in the first cycle after reset release
// Function
// RULE1: Disable bit suspends all monitoring; otherwise gather attribute data during reads/writes.
// RULE2: Online-only select blocks every off-line measurement.
// RULE3: Rezero command measures, saves and restarts the one-hour timer.
// RULE4: Time left until next measurement is readable by the host.
// RULE5: Hourly measure-and-save waits for interface idle and host activity aborts it.
// RULE6: On-line processing holds command handling at most 75 ms.
// RULE7: Predictive failure reports sense 01-5D00 with attribute type in failure code.
// RULE8: Recorded predictive failure code survives bus resets and power cycles.
// RULE9: Interval and failure counters judge each interval and then restart.
// RULE10: History counter up on bad interval, down on good, floor zero.
// RULE11: History reaching predictive threshold signals predictive failure.
// RULE12: Sample temperature at power-up and every ten minutes after.
// RULE13: Over trip point: warn 01-0B01, temperature as code, save frame if threatening.
// RULE14: Temperature warnings only when enabled, delivered per report method.
// RULE15: Two trip points: fixed maximum and host reference, default 65, range 0-65.
// RULE16: Reference above maximum is clamped and a rounded-parameter sense returned.
// RULE17: Temperature log reports current and reference temperature.
// RULE18: Diagnostic function code 001b starts short test, 010b extended test.
// RULE19: Host issues diagnostics only when ready and finds not-ready causes itself.
// RULE20: Short test finishes within 120 seconds with a partial scan.
// RULE21: Each test runs electrical phase, then scan; extended scans every block.
// RULE22: Only unrecovered read/write errors fail a test.
// RULE23: Starting a test inserts a new head entry, newest 20 kept, result Fh.
// RULE24: Result is four bits, zero pass, nonzero gives failure reason.
// RULE25: Per-attribute limits are loaded from non-volatile storage after reset.
//
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "health_defs.svh"
module drive_health_monitor #(
  parameter int unsigned SEC_CYCLES = `SEC_CYCLES,
  parameter int unsigned DELAY_CYCLES = `DELAY_CYCLES,
  parameter int unsigned MEAS_CYCLES = `MEAS_CYCLES
) (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Sync reset
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  input wire logic host_activity, // Interface busy
  input wire logic [`NATTR-1:0] attr_op, // Operation pulses
  input wire logic [`NATTR-1:0] attr_err, // Error pulses
  input wire health_pkg::attr_cfg_s [`NATTR-1:0] nv_cfg, // Stored limits
  input wire logic [7:0] nv_pfa_code, // Stored failure code
  input wire logic temp_valid, // Temperature sample ready
  input wire logic [7:0] temp_value, // Temperature in C
  output logic temp_req, // Take a sample
  output logic frame_save, // Save data frame
  output logic meas_busy, // Off-line pass running
  output logic meas_save, // Save attribute data
  output logic exc_valid, // Exception report pulse
  output health_pkg::sense_s exc_sense, // Exception sense data
  output logic pfa_store, // Store failure code pulse
  output logic [7:0] pfa_code, // Failure code to store
  input wire logic [31:0] max_lba, // Last block address
  input wire logic step_ack, // Test step done
  input wire logic step_unrec, // Test step unrecovered error
  output health_pkg::step_s step // Test step request
);
  import health_pkg::*;
  localparam int unsigned MEAS_LAST = ((MEAS_CYCLES < DELAY_CYCLES) ?
                                       MEAS_CYCLES : DELAY_CYCLES) - 1;
  typedef struct packed {
    logic loaded;
    logic dis;
    logic onl;
    logic twe;
    logic [3:0] report_method;
    logic [7:0] ref_t;
    logic [7:0] cur_t;
    logic rounded;
    logic twarn;
    sense_s sense;
    logic exc_valid;
    logic [7:0] pfa_code;
    logic pfa_store;
    logic [`NATTR-1:0] pfa_seen;
    attr_cfg_s [`NATTR-1:0] cfg;
    logic [31:0] sec_div;
    logic sec_tick;
    meas_e mst;
    logic meas_busy;
    logic meas_save;
    logic [31:0] busy_cnt;
    logic [11:0] meas_left;
    logic [7:0] idle_cnt;
    logic [9:0] temp_left;
    logic temp_req;
    logic frame_save;
    logic st_start;
    logic [2:0] st_fc;
    logic [4:0] log_sel;
    logic [`LOG_DEPTH-1:0][6:0] log;
    logic [31:0] rdata;
  } st_s;
  st_s q, d;
  logic [`NATTR-1:0] pfa_vec, pfa_one;
  logic trk_en, cmd_wr, pfa_hit, ovr_max, ovr_ref, st_busy, st_done;
  logic [7:0] pfa_unit;
  logic [2:0] fc;
  logic [3:0] st_result;
  // ----------------------------------------
  // Attribute trackers and self-test
  // ----------------------------------------
  assign trk_en = q.loaded && !q.dis; // RULE1
  genvar g;
  generate
    for (g = 0; g < `NATTR; g++) begin : g_attr
      attr_rate_tracker u_trk (
        .core_clk(core_clk),
        .rst(rst),
        .en(trk_en),
        .op(attr_op[g]),
        .err(attr_err[g]),
        .cfg(q.cfg[g]),
        .pfa(pfa_vec[g])
      );
    end
  endgenerate
  self_test_engine u_st (
    .core_clk(core_clk),
    .rst(rst),
    .sec_tick(q.sec_tick),
    .start(q.st_start),
    .fcode(q.st_fc),
    .max_lba(max_lba),
    .step_ack(step_ack),
    .step_unrec(step_unrec),
    .step(step),
    .busy(st_busy),
    .done(st_done),
    .result(st_result)
  );
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    cmd_wr = reg_wr && (reg_addr == `A_CMD);
    fc = reg_wdata[`CMD_FC_HI:`CMD_FC_LO];
    d.sec_tick = 1'b0;
    d.temp_req = 1'b0;
    d.frame_save = 1'b0;
    d.meas_save = 1'b0;
    d.exc_valid = 1'b0;
    d.pfa_store = 1'b0;
    d.st_start = 1'b0;
    d.rdata = '0;
    if (!q.loaded) begin
      d.loaded = 1'b1;
      d.ref_t = `REF_RST; // RULE15
      d.cfg = nv_cfg; // RULE25
      d.pfa_code = nv_pfa_code; // RULE8
    end
    if (q.sec_div == 32'(SEC_CYCLES - 1)) begin
      d.sec_div = '0;
      d.sec_tick = 1'b1;
    end else begin
      d.sec_div = q.sec_div + 32'h1;
    end
    if (host_activity) d.idle_cnt = '0;
    else if (q.idle_cnt != 8'(`IDLE_CYCLES)) d.idle_cnt = q.idle_cnt + 8'h01;
    // Register writes; clears come first so that hardware sets below win
    if (reg_wr) begin
      case (reg_addr)
        `A_CTRL: begin
          d.dis = reg_wdata[`C_DIS];
          d.onl = reg_wdata[`C_ONL];
          d.twe = reg_wdata[`C_TWE];
          d.report_method = reg_wdata[`C_RPT_HI:`C_RPT_LO];
        end
        `A_STATUS: begin
          if (reg_wdata[`S_TWARN]) d.twarn = 1'b0;
          if (reg_wdata[`S_ROUND]) d.rounded = 1'b0;
        end
        `A_TEMP_REF: begin
          if (reg_wdata[31:8] != 24'h0 || reg_wdata[7:0] > `REF_MAX) begin
            d.ref_t = `REF_MAX; // RULE16
            d.rounded = 1'b1; // RULE16
            d.exc_valid = 1'b1;
            d.sense = '{`RND_KEY, `RND_ASC, `RND_ASCQ, 8'h00}; // RULE16
          end else begin
            d.ref_t = reg_wdata[7:0]; // RULE15
          end
        end
        `A_LOG_SEL: d.log_sel = reg_wdata[4:0];
        `A_CMD: begin
          if ((fc == `FC_SHORT || fc == `FC_EXT) && !st_busy && !q.st_start) begin // RULE18
            d.st_start = 1'b1;
            d.st_fc = fc;
            d.log = {q.log[`LOG_DEPTH-2:0], {fc, `RES_RUN}}; // RULE23
          end
        end
        default: ;
      endcase
    end
    if (st_done) d.log[0][3:0] = st_result; // RULE24
    // Measurement timer, frozen while monitoring is off
    if (q.sec_tick && !q.dis && q.meas_left != 12'h0) d.meas_left = q.meas_left - 12'h001; // RULE5
    unique case (q.mst)
      M_WAIT: begin
        if (cmd_wr && reg_wdata[`CMD_REZERO] && !q.dis) begin
          d.meas_left = 12'(`MEAS_PERIOD_S); // RULE3
          if (!q.onl) begin // RULE2
            d.mst = M_MEAS; // RULE3
            d.busy_cnt = '0;
          end
        end else if (q.meas_left == 12'h0 && !q.dis) begin
          if (q.onl) begin
            d.meas_left = 12'(`MEAS_PERIOD_S); // RULE2
          end else if (q.idle_cnt == 8'(`IDLE_CYCLES) && !host_activity) begin
            d.mst = M_MEAS; // RULE5
            d.busy_cnt = '0;
          end
        end
      end
      M_MEAS: begin
        d.busy_cnt = q.busy_cnt + 32'h1;
        // Timer stays at zero after an aborted hourly pass, so that pass retries at the next idle gap
        if (host_activity) begin
          d.mst = M_WAIT; // RULE5
        end else if (q.busy_cnt == 32'(MEAS_LAST)) begin
          d.mst = M_WAIT; // RULE6
          d.meas_save = 1'b1; // RULE3
          d.meas_left = 12'(`MEAS_PERIOD_S);
        end
      end
    endcase
    d.meas_busy = (d.mst == M_MEAS);
    // Temperature sampling runs even while monitoring is off
    if (q.sec_tick && q.temp_left != 10'h0) begin
      d.temp_left = q.temp_left - 10'h001;
    end else if (q.temp_left == 10'h0 && q.loaded) begin
      d.temp_left = 10'(`TEMP_PERIOD_S); // RULE12
      d.temp_req = 1'b1; // RULE12
    end
    ovr_max = temp_value > `DRIVE_MAX_C; // RULE15
    ovr_ref = temp_value > q.ref_t; // RULE15
    if (temp_valid) begin
      d.cur_t = temp_value; // RULE17
      if ((ovr_max || ovr_ref) && q.twe && !q.dis) begin // RULE14
        d.twarn = 1'b1;
        if (q.report_method != 4'h0) begin // RULE14
          d.exc_valid = 1'b1;
          d.sense = '{`TW_KEY, `TW_ASC, `TW_ASCQ, temp_value}; // RULE13
        end
      end
      if (ovr_max && !q.dis) d.frame_save = 1'b1; // RULE13
    end
    // Lowest attribute wins; a failure report overrides a warning in the same cycle
    pfa_hit = 1'b0;
    pfa_unit = 8'h00;
    pfa_one = '0;
    for (int i = `NATTR - 1; i >= 0; i--) begin
      if (pfa_vec[i] && !q.pfa_seen[i]) begin
        pfa_hit = 1'b1;
        pfa_unit = 8'(i + 1);
        pfa_one = '0;
        pfa_one[i] = 1'b1;
      end
    end
    if (pfa_hit && trk_en) begin
      d.pfa_seen = q.pfa_seen | pfa_one;
      d.pfa_code = pfa_unit; // RULE8
      d.pfa_store = 1'b1; // RULE8
      if (q.report_method != 4'h0) begin
        d.exc_valid = 1'b1;
        d.sense = '{`PFA_KEY, `PFA_ASC, `PFA_ASCQ, pfa_unit}; // RULE7
      end
    end
    if (reg_rd) begin
      case (reg_addr)
        `A_CTRL: d.rdata = {24'h0, q.report_method, 1'b0, q.twe, q.onl, q.dis};
        `A_STATUS: d.rdata = {20'h0, q.log[0][3:0], 4'h0, st_busy, q.rounded, q.twarn,
                              q.pfa_code != 8'h00};
        `A_SENSE: d.rdata = q.sense;
        `A_REMAIN: d.rdata = {20'h0, q.meas_left}; // RULE4
        `A_TEMP_CUR: d.rdata = {24'h0, q.cur_t}; // RULE17
        `A_TEMP_REF: d.rdata = {24'h0, q.ref_t}; // RULE17
        `A_LOG_SEL: d.rdata = {27'h0, q.log_sel};
        `A_LOG_DATA: d.rdata = (q.log_sel < 5'(`LOG_DEPTH)) ? {25'h0, q.log[q.log_sel]} : '0;
        default: d.rdata = '0;
      endcase
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) q <= '0;
    else q <= d;
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata = q.rdata;
  assign temp_req = q.temp_req;
  assign frame_save = q.frame_save;
  assign meas_busy = q.meas_busy;
  assign meas_save = q.meas_save;
  assign exc_valid = q.exc_valid;
  assign exc_sense = q.sense;
  assign pfa_store = q.pfa_store;
  assign pfa_code = q.pfa_code;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_dis_idle;
    @(posedge core_clk) disable iff (rst) (q.dis && !q.meas_busy) |=> !q.meas_busy && !q.pfa_store;
  endproperty
  a_dis_idle: assert property (p_dis_idle) else $error("monitor ran while disabled"); // RULE1
  property p_onl;
    @(posedge core_clk) disable iff (rst) (q.onl && !q.meas_busy) |=> !q.meas_busy;
  endproperty
  a_onl: assert property (p_onl) else $error("off-line pass in online-only mode"); // RULE2
  property p_rezero;
    @(posedge core_clk) disable iff (rst)
      (cmd_wr && reg_wdata[`CMD_REZERO] && !q.dis && !q.meas_busy) |=>
      q.meas_left == 12'(`MEAS_PERIOD_S) && (q.onl || q.meas_busy);
  endproperty
  a_rezero: assert property (p_rezero) else $error("rezero did not restart timer"); // RULE3
  property p_remain;
    @(posedge core_clk) disable iff (rst)
      (reg_rd && reg_addr == `A_REMAIN) |=> reg_rdata == {20'h0, $past(q.meas_left)};
  endproperty
  a_remain: assert property (p_remain) else $error("wrong time remaining"); // RULE4
  property p_abort;
    @(posedge core_clk) disable iff (rst) (q.meas_busy && host_activity) |=> !q.meas_busy && !q.meas_save;
  endproperty
  a_abort: assert property (p_abort) else $error("host did not interrupt pass"); // RULE5
  property p_delay;
    @(posedge core_clk) disable iff (rst) q.meas_busy |-> q.busy_cnt < 32'(DELAY_CYCLES);
  endproperty
  a_delay: assert property (p_delay) else $error("on-line delay too long"); // RULE6
  property p_pfa_sense;
    @(posedge core_clk) disable iff (rst) (pfa_hit && trk_en && q.report_method != 4'h0) |=>
      q.exc_valid && q.sense.asc == `PFA_ASC && q.sense.unit_code == q.pfa_code;
  endproperty
  a_pfa_sense: assert property (p_pfa_sense) else $error("predictive failure not reported"); // RULE7
  property p_temp_warn;
    @(posedge core_clk) disable iff (rst)
      (temp_valid && temp_value > q.ref_t && q.twe && !q.dis) |=> q.twarn;
  endproperty
  a_temp_warn: assert property (p_temp_warn) else $error("missed temperature warning"); // RULE14
  property p_clamp;
    @(posedge core_clk) disable iff (rst)
      (reg_wr && reg_addr == `A_TEMP_REF && reg_wdata[7:0] > `REF_MAX) |=>
      q.ref_t == `REF_MAX && q.rounded && q.sense.asc == `RND_ASC;
  endproperty
  a_clamp: assert property (p_clamp) else $error("reference not clamped"); // RULE16
  property p_pwrup_temp;
    @(posedge core_clk) disable iff (rst) $rose(q.loaded) |=> q.temp_req;
  endproperty
  a_pwrup_temp: assert property (p_pwrup_temp) else $error("no power-up sample"); // RULE12
endmodule // drive_health_monitor
`default_nettype wire

// ### bench/step_partner.sv
// Purpose: media-side responder to self-test step requests
// Assumes: ack is one cycle, given only while the request is high
// Notes: bit 32 of bad_lba arms an unrecovered failure on every scan of that block
`timescale 1ns/1ps
`default_nettype none
module step_partner (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Sync reset
  input wire health_pkg::step_s step, // Step request
  input wire logic [32:0] bad_lba, // Failing block, bit 32 arms
  output logic step_ack, // Step done
  output logic step_unrec // Unrecovered error
);
  import health_pkg::*;
  logic [1:0] wait_q;
  logic fire;
  // Gap after each ack lets the next block address settle
  assign fire = step.req && !step_ack && wait_q == 2'h0;
  always_ff @(posedge core_clk) begin
    wait_q <= (rst || step_ack) ? 2'h2 : wait_q - {1'b0, step.req && wait_q != 2'h0};
    step_ack <= !rst && fire;
    step_unrec <= !rst && fire && bad_lba[32] && step.scan && step.lba == bad_lba[31:0];
  end
endmodule // step_partner
`default_nettype wire

// ### bench/tb_drive_health_monitor.sv
// Purpose: self-checking bench of the drive health monitor
// Assumes: shortened second, delay and pass counts
// Notes: fixed seed, expectations from bench functions
`timescale 1ns/1ps
`default_nettype none
`include "health_defs.svh"
module tb_drive_health_monitor;
  import health_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, host_activity = 1'b0;
  logic temp_valid = 1'b0;
  logic [7:0] reg_addr = 8'h00, temp_value = 8'h00, pfa_code;
  logic [31:0] reg_wdata = 0, reg_rdata, d, seed = 40452;
  logic [3:0] attr_op = 4'h0, attr_err = 4'h0;
  logic temp_req, frame_save, meas_busy, meas_save, exc_valid, pfa_store, step_ack, step_unrec;
  logic [32:0] bad_lba = '0;
  attr_cfg_s [3:0] nv_cfg;
  sense_s exc_sense;
  step_s step;
  int n_mismatch = 0, total_checks = 0, cyc = 0, n_exc = 0, e;
  assign nv_cfg = {{3{40'h0008000200}}, 40'h0004000102};
  drive_health_monitor #(.SEC_CYCLES(10), .DELAY_CYCLES(50), .MEAS_CYCLES(20)) i_dut (
    .core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .host_activity,
    .attr_op, .attr_err, .nv_cfg, .nv_pfa_code(8'h00), .temp_valid, .temp_value, .temp_req,
    .frame_save, .meas_busy, .meas_save, .exc_valid, .exc_sense, .pfa_store, .pfa_code,
    .max_lba(32'h3), .step_ack, .step_unrec, .step);
  step_partner i_step (.core_clk, .rst, .step, .bad_lba, .step_ack, .step_unrec);
  initial forever #2 core_clk = ~core_clk;
  always @(negedge core_clk) n_exc += exc_valid;
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [31:0] ref_exp(input logic [7:0] v);
    return (v > `REF_MAX) ? `REF_MAX : v;
  endfunction
  task automatic chk(input logic [31:0] seen, exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic send(input logic [7:0] t);
    @(posedge core_clk);
    temp_valid <= 1'b1;
    temp_value <= t;
    attr_op <= {3'(rnd() % 8), 1'b0};
    @(posedge core_clk);
    temp_valid <= 1'b0;
    attr_op <= 4'h0;
  endtask
  task automatic wait_test();
    d = 8;
    for (int i = 0; i < 900 && d[3]; i++) rd(`A_STATUS, d);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk(temp_req, 1, "power-up sample");
    rd(`A_TEMP_REF, d);
    chk(d, 32'h41, "ref reset");
    wr(`A_TEMP_REF, 32'h50);
    rd(`A_TEMP_REF, d);
    chk(d, ref_exp(8'h50), "ref clamp");
    rd(`A_STATUS, d);
    chk(d[2], 1, "rounded");
    rd(8'h3C, d);
    chk(d, 0, "unmapped");
    wr(`A_TEMP_REF, 32'h30);
    wr(`A_CTRL, 32'h14);
    for (int i = 0; i < 8; i++) begin
      e = rnd() % 48;
      send(8'(e));
      rd(`A_TEMP_CUR, d);
      chk(d, e, "temp cur");
    end
    send(8'h48);
    #1 chk(frame_save, 1, "frame save");
    rd(`A_SENSE, d);
    chk(d, 32'h010B0148, "temp sense");
    wr(`A_CTRL, 32'h15);
    e = n_exc;
    send(8'h49);
    repeat (3) @(posedge core_clk);
    chk(n_exc, e, "disabled report");
    wr(`A_CTRL, 32'h14);
    $display("thermal test done");
    wr(`A_CMD, 32'h20);
    wait_test();
    rd(`A_LOG_DATA, d);
    chk(d, 32'h10, "short pass");
    bad_lba <= {1'b1, 32'h2};
    wr(`A_CMD, 32'h40);
    rd(`A_LOG_DATA, d);
    chk(d, 32'h2F, "head running");
    wait_test();
    rd(`A_LOG_DATA, d);
    chk(d, 32'h27, "scan fail");
    wr(`A_LOG_SEL, 32'h1);
    rd(`A_LOG_DATA, d);
    chk(d, 32'h10, "older entry");
    $display("self-test done");
    repeat (6) begin
      @(posedge core_clk);
      attr_err <= 4'h1;
      @(posedge core_clk);
      attr_err <= 4'h0;
    end
    repeat (4) @(posedge core_clk);
    rd(`A_SENSE, d);
    chk(d, 32'h015D0001, "pfa sense");
    chk(pfa_code, 1, "pfa code");
    $display("pfa test done");
    wr(`A_CMD, 32'h1);
    rd(`A_REMAIN, d);
    chk(d == 32'hE10 || d == 32'hE0F, 1, "remain");
    chk(meas_busy, 1, "pass start");
    for (int i = 0; i < 300 && !meas_busy; i++) @(posedge core_clk);
    host_activity <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 chk(meas_busy, 0, "abort pass");
    $display("measure test done");
    summarize();
  end
endmodule // tb_drive_health_monitor
`default_nettype wire
